/* rtl/remote_cmd_pkg.sv */
// Shared constants and carriers of the serial remote command handler.
// Assumes an ASCII character stream from a serial port on the same clock.
package remote_cmd_pkg;

    localparam logic [7:0] CH_SPACE   = 8'h20;
    localparam logic [7:0] CH_CR      = 8'h0D;
    localparam logic [7:0] CH_LF      = 8'h0A;
    localparam logic [7:0] CH_PERIOD  = 8'h2E;
    localparam logic [7:0] CH_MINUS   = 8'h2D;
    localparam logic [7:0] CH_ZERO    = 8'h30;
    localparam logic [7:0] CH_ONE     = 8'h31;
    localparam logic [7:0] CH_NINE    = 8'h39;
    localparam logic [7:0] CH_ERR     = 8'h3F;
    localparam logic [7:0] CH_QUERY   = 8'h49;

    localparam int CMD_CHARS   = 11;
    localparam int PARAM_CHARS = 8;
    localparam int CMD_W       = 8 * CMD_CHARS;

    // Command words are right-aligned ASCII; zero bytes fill the unused leading places.
    localparam logic [CMD_W-1:0] SETPOINT_ONE_WRITE_CMD = {16'h0000, 72'h4F55545F53505F3030};
    localparam logic [CMD_W-1:0] SETPOINT_ONE_READ_CMD  = {24'h000000, 64'h494E5F53505F3030};
    localparam logic [CMD_W-1:0] CMD_RUN_WR = "OUT_MODE_05";
    localparam logic [CMD_W-1:0] CMD_RUN_RD = {8'h00, "IN_MODE_05"};

    localparam logic [1:0] REPLY_SP  = 2'h0;
    localparam logic [1:0] REPLY_RUN = 2'h1;
    localparam logic [1:0] REPLY_ERR = 2'h2;

    localparam logic [23:0] SCALE_UNITS  = 24'h000064;
    localparam logic [23:0] SCALE_TENTHS = 24'h00000A;
    localparam logic [23:0] DEC_BASE     = 24'h00000A;
    localparam logic [1:0]  FRAC_MAX     = 2'h2;

    typedef struct packed {
        logic       valid;
        logic [7:0] data;
    } byte_beat_t;

    typedef enum logic [2:0] {
        ST_WORD  = 3'b000,
        ST_PARAM = 3'b001,
        ST_EXEC  = 3'b011,
        ST_REPLY = 3'b010,
        ST_LF    = 3'b110,
        ST_SKIP  = 3'b100
    } parse_state_t;

endpackage

/* rtl/serial_port.sv */
// Asynchronous serial receiver and transmitter with configurable framing.
// Assumes rxd_pin is asynchronous to clk and idles high.
`timescale 1ns/100ps
module serial_port
    import remote_cmd_pkg::*;
#(
    parameter int CLK_HZ    = 100_000_000,
    parameter int BAUD      = 9600,
    parameter int DATA_BITS = 8,
    parameter int PARITY    = 0,
    parameter int STOP_BITS = 1
)(
    input  wire logic       clk,
    input  wire logic       sys_rst,
    input  wire logic       rxd_pin,
    output byte_beat_t      rx_beat,
    input  wire byte_beat_t tx_beat,
    output logic            tx_ready,
    output logic            txd
);
    localparam int          FRAME  = 1 + DATA_BITS + STOP_BITS + ((PARITY != 0) ? 1 : 0);
    localparam int          DIV    = CLK_HZ / BAUD;
    localparam logic [15:0] DIV_M1 = 16'(DIV - 1);
    localparam logic [15:0] DIV_H  = 16'(DIV / 2);
    localparam logic [3:0]  LAST   = 4'(FRAME - 1);

    if (DATA_BITS < 5 || DATA_BITS > 8 || PARITY > 2 || STOP_BITS < 1 || STOP_BITS > 2
        || DIV < 4 || DIV > 65535) begin : g_bad_cfg
        $error("serial_port: unsupported framing or baud divisor");
    end

    // Odd parity when PARITY is 1, even when 2.
    function automatic logic par_bit(input logic [DATA_BITS-1:0] d);
        par_bit = (^d) ^ (PARITY == 1);
    endfunction

    logic             s1_q, s2_q, s3_q, rx_lvl_q;
    logic             rx_busy_q;
    logic [15:0]      rx_cnt_q;
    logic [3:0]       rx_idx_q;
    logic [FRAME-1:0] rx_sh_q, rx_full;

    always_ff @(posedge clk)
    begin
        s1_q <= rxd_pin;
        s2_q <= s1_q;
        s3_q <= s2_q;
        if (sys_rst)
            rx_lvl_q <= 1'b1;
        else if (s2_q == s3_q)
            rx_lvl_q <= s3_q;
    end

    assign rx_full = {rx_lvl_q, rx_sh_q[FRAME-1:1]};

    always_ff @(posedge clk)
    begin
        rx_beat.valid <= 1'b0;
        if (sys_rst)
        begin
            rx_busy_q    <= 1'b0;
            rx_cnt_q     <= '0;
            rx_idx_q     <= '0;
            rx_sh_q      <= '0;
            rx_beat.data <= '0;
        end
        else if (!rx_busy_q && !rx_lvl_q)
        begin
            rx_busy_q <= 1'b1;
            rx_cnt_q  <= DIV_H;
            rx_idx_q  <= '0;
        end
        else if (rx_busy_q)
        begin
            if (rx_cnt_q == '0)
            begin
                rx_cnt_q <= DIV_M1;
                rx_sh_q  <= rx_full;
                rx_idx_q <= rx_idx_q + 4'h1;
                if (rx_idx_q == LAST)
                begin
                    // Framing or parity faults drop the character silently.
                    rx_busy_q     <= 1'b0;
                    rx_beat.valid <= !rx_full[0] && rx_full[FRAME-1]
                        && (PARITY == 0 || rx_full[DATA_BITS+1] == par_bit(rx_full[DATA_BITS:1]));
                    rx_beat.data  <= '0;
                    rx_beat.data[DATA_BITS-1:0] <= rx_full[DATA_BITS:1];
                end
            end
            else
                rx_cnt_q <= rx_cnt_q - 16'h0001;
        end
    end

    logic [15:0]      tx_cnt_q;
    logic [3:0]       tx_idx_q;
    logic [FRAME-1:0] tx_sh_q, tx_frame;

    always_comb
    begin
        tx_frame = '1;
        tx_frame[0] = 1'b0;
        tx_frame[DATA_BITS:1] = tx_beat.data[DATA_BITS-1:0];
        if (PARITY != 0)
            tx_frame[DATA_BITS+1] = par_bit(tx_beat.data[DATA_BITS-1:0]);
    end

    always_ff @(posedge clk)
    begin
        if (sys_rst)
        begin
            tx_ready <= 1'b1;
            txd      <= 1'b1;
            tx_cnt_q <= '0;
            tx_idx_q <= '0;
            tx_sh_q  <= '1;
        end
        else if (tx_ready)
        begin
            if (tx_beat.valid)
            begin
                tx_ready <= 1'b0;
                tx_sh_q  <= tx_frame;
                txd      <= 1'b0;
                tx_cnt_q <= DIV_M1;
                tx_idx_q <= '0;
            end
        end
        else if (tx_cnt_q == '0)
        begin
            tx_cnt_q <= DIV_M1;
            tx_idx_q <= tx_idx_q + 4'h1;
            if (tx_idx_q == LAST)
            begin
                tx_ready <= 1'b1;
                txd      <= 1'b1;
            end
            else
                txd <= tx_sh_q[tx_idx_q+4'h1];
        end
        else
            tx_cnt_q <= tx_cnt_q - 16'h0001;
    end

endmodule

/* rtl/serial_remote_command_handler.sv */
// Remote command interpreter: parses ASCII frames, applies settings, answers queries.
// Assumes remote_menu_on and local_run come from keypad logic on clk.
//
// What this block does
// - Transmits only as reply to host queries.
// - Frame is command, space, parameter, carriage return.
// - Parameters are decimal ASCII with period separator.
// - Query commands read; setting commands write.
// - Every well-formed query answered with data, or ? if unknown, then line feed.
// - Setting commands act only in remote mode.
// - Entering remote mode forces and shows remote stop.
// - No automatic restart after power returns.
// - Remote mode enabled by keypad menu item.
// - Interface settings survive power off.
`timescale 1ns/100ps
module serial_remote_command_handler
    import remote_cmd_pkg::*;
#(
    parameter int CLK_HZ    = 100_000_000,
    parameter int BAUD      = 9600,
    parameter int DATA_BITS = 8,
    parameter int PARITY    = 0,
    parameter int STOP_BITS = 1
)(
    input  wire logic          clk,
    input  wire logic          sys_rst,
    input  wire logic          rxd,
    input  wire logic          remote_menu_on,
    input  wire logic          local_run,
    output logic               txd,
    output logic               remote_active,
    output logic               remote_stop_shown,
    output logic               unit_run,
    output logic signed [23:0] first_working_setpoint
);
    localparam int PI_W = $clog2(PARAM_CHARS);
    localparam int PL_W = $clog2(PARAM_CHARS + 1);
    localparam logic [PL_W-1:0] PL_MAX = PL_W'(PARAM_CHARS);
    localparam logic [3:0]      CW_MAX = 4'(CMD_CHARS);
    // Generous bound of a whole reply: every character is allowed sixteen bit times.
    localparam int              REPLY_LIMIT = (PARAM_CHARS + 2) * 16 * (CLK_HZ / BAUD);

    // Interface settings are elaboration constants, so nothing is lost at power off.
    byte_beat_t rx_beat, tx_beat;
    logic       tx_ready;

    serial_port #(
        .CLK_HZ    (CLK_HZ),
        .BAUD      (BAUD),
        .DATA_BITS (DATA_BITS),
        .PARITY    (PARITY),
        .STOP_BITS (STOP_BITS)
    ) u_port (
        .clk      (clk),
        .sys_rst  (sys_rst),
        .rxd_pin  (rxd),
        .rx_beat  (rx_beat),
        .tx_beat  (tx_beat),
        .tx_ready (tx_ready),
        .txd      (txd)
    );

    function automatic logic is_param_char(input logic [7:0] ch);
        is_param_char = (ch >= CH_ZERO && ch <= CH_NINE) || ch == CH_PERIOD || ch == CH_MINUS;
    endfunction

    parse_state_t     state_q;
    logic [CMD_W-1:0] word_q;
    logic [3:0]       word_len_q;
    logic [7:0]       first_ch_q;
    logic [7:0]       param_q [PARAM_CHARS];
    logic [PL_W-1:0]  param_len_q;
    logic [23:0]      acc_q;
    logic [1:0]       frac_q;
    logic             dot_q, neg_q;
    logic [7:0]       sp_text_q [PARAM_CHARS];
    logic [PL_W-1:0]  sp_len_q;
    logic [1:0]       reply_sel_q;
    logic [PL_W-1:0]  reply_idx_q;
    logic             run_q;
    logic [31:0]      reply_cnt_q;

    logic             is_sp_wr, is_run_wr, is_sp_rd, is_run_rd, is_query, tx_take;
    logic [23:0]      mag;
    logic signed [23:0] scaled;
    logic [7:0]       reply_char;
    logic [PL_W-1:0]  reply_len;

    assign is_sp_wr  = word_q == SETPOINT_ONE_WRITE_CMD;
    assign is_run_wr = word_q == CMD_RUN_WR;
    assign is_sp_rd  = word_q == SETPOINT_ONE_READ_CMD;
    assign is_run_rd = word_q == CMD_RUN_RD;
    assign is_query  = first_ch_q == CH_QUERY;
    assign tx_take   = tx_beat.valid && tx_ready;

    always_comb
    begin
        mag = (frac_q == 2'h0) ? 24'(acc_q * SCALE_UNITS)
            : (frac_q == 2'h1) ? 24'(acc_q * SCALE_TENTHS) : acc_q;
        scaled = neg_q ? -$signed(mag) : $signed(mag);
        reply_len = (reply_sel_q == REPLY_SP) ? sp_len_q : PL_W'(1);
        unique case (reply_sel_q)
            REPLY_SP:  reply_char = sp_text_q[reply_idx_q[PI_W-1:0]];
            REPLY_RUN: reply_char = run_q ? CH_ONE : CH_ZERO;
            default:   reply_char = CH_ERR;
        endcase
        // The transmitter is fed only while answering a query.
        tx_beat.valid = (state_q == ST_REPLY) || (state_q == ST_LF);
        tx_beat.data  = (state_q == ST_LF) ? CH_LF : reply_char;
    end

    // Frame parser and reply sequencer.
    always_ff @(posedge clk)
    begin
        if (sys_rst)
            state_q <= ST_WORD;
        else
        begin
            unique case (state_q)
                ST_WORD:
                    if (rx_beat.valid)
                    begin
                        if (rx_beat.data == CH_CR)
                            state_q <= (word_len_q != '0) ? ST_EXEC : ST_WORD;
                        else if (rx_beat.data == CH_SPACE)
                            state_q <= (word_len_q != '0) ? ST_PARAM : ST_SKIP;
                        else if (word_len_q == CW_MAX)
                            state_q <= ST_SKIP;
                    end
                ST_PARAM:
                    if (rx_beat.valid)
                    begin
                        if (rx_beat.data == CH_CR)
                            state_q <= ST_EXEC;
                        else if (!is_param_char(rx_beat.data) || param_len_q == PL_MAX)
                            state_q <= ST_SKIP;
                    end
                ST_EXEC:
                    state_q <= is_query ? ST_REPLY : ST_WORD;
                ST_REPLY:
                    if (tx_take && reply_idx_q + PL_W'(1) >= reply_len)
                        state_q <= ST_LF;
                ST_LF:
                    if (tx_take)
                        state_q <= ST_WORD;
                ST_SKIP:
                    // Malformed frames are discarded without an error report.
                    if (rx_beat.valid && rx_beat.data == CH_CR)
                        state_q <= ST_WORD;
                default:
                    state_q <= ST_WORD;
            endcase
        end
    end

    // Command word and parameter capture.
    always_ff @(posedge clk)
    begin
        // A skipped frame must leave no digits behind for the next command.
        if (sys_rst || state_q == ST_EXEC || state_q == ST_SKIP)
        begin
            word_q      <= '0;
            word_len_q  <= '0;
            first_ch_q  <= '0;
            param_len_q <= '0;
            acc_q       <= '0;
            frac_q      <= '0;
            dot_q       <= 1'b0;
            neg_q       <= 1'b0;
        end
        else if (rx_beat.valid && state_q == ST_WORD && rx_beat.data != CH_CR
                 && rx_beat.data != CH_SPACE && word_len_q != CW_MAX)
        begin
            word_q     <= {word_q[CMD_W-9:0], rx_beat.data};
            word_len_q <= word_len_q + 4'h1;
            if (word_len_q == '0)
                first_ch_q <= rx_beat.data;
        end
        else if (rx_beat.valid && state_q == ST_PARAM && is_param_char(rx_beat.data)
                 && param_len_q != PL_MAX)
        begin
            param_q[param_len_q[PI_W-1:0]] <= rx_beat.data;
            param_len_q <= param_len_q + PL_W'(1);
            if (rx_beat.data == CH_MINUS)
                neg_q <= 1'b1;
            else if (rx_beat.data == CH_PERIOD)
                dot_q <= 1'b1;
            else if (!dot_q || frac_q != FRAC_MAX)
            begin
                // Digits beyond hundredths are kept in the echo text but not in the value.
                acc_q <= 24'(acc_q * DEC_BASE) + 24'(rx_beat.data - CH_ZERO);
                if (dot_q)
                    frac_q <= frac_q + 2'h1;
            end
        end
    end

    // Stored setpoint and reply pointer.
    always_ff @(posedge clk)
    begin
        if (sys_rst)
        begin
            first_working_setpoint <= '0;
            sp_text_q   <= '{default: CH_ZERO};
            sp_len_q    <= PL_W'(1);
            reply_sel_q <= REPLY_ERR;
            reply_idx_q <= '0;
        end
        else if (state_q == ST_EXEC)
        begin
            reply_idx_q <= '0;
            reply_sel_q <= is_sp_rd ? REPLY_SP : is_run_rd ? REPLY_RUN : REPLY_ERR;
            if (remote_active && is_sp_wr && param_len_q != '0)
            begin
                first_working_setpoint <= scaled;
                sp_text_q <= param_q;
                sp_len_q  <= param_len_q;
            end
        end
        else if (state_q == ST_REPLY && tx_take)
            reply_idx_q <= reply_idx_q + PL_W'(1);
    end

    // Remote mode follows the keypad menu item; entering it forces a stop.
    always_ff @(posedge clk)
    begin
        if (sys_rst)
        begin
            remote_active <= 1'b0;
            run_q         <= 1'b0;
        end
        else
        begin
            remote_active <= remote_menu_on;
            if (remote_menu_on && !remote_active)
                run_q <= 1'b0;
            else if (state_q == ST_EXEC && remote_active && is_run_wr && param_len_q == PL_W'(1))
            begin
                if (param_q[0] == CH_ONE)
                    run_q <= 1'b1;
                else if (param_q[0] == CH_ZERO)
                    run_q <= 1'b0;
            end
        end
    end

    always_ff @(posedge clk)
    begin
        if (sys_rst)
        begin
            remote_stop_shown <= 1'b0;
            unit_run          <= 1'b0;
        end
        else
        begin
            remote_stop_shown <= remote_active && !run_q;
            unit_run          <= remote_active ? run_q : local_run;
        end
    end

    property p_no_unsolicited;
        @(posedge clk) disable iff (sys_rst)
        $rose(state_q == ST_REPLY) |-> $past(state_q) == ST_EXEC && $past(first_ch_q) == CH_QUERY;
    endproperty
    a_no_unsolicited: assert property (p_no_unsolicited) else $error("reply without query");

    property p_space_opens_param;
        @(posedge clk) disable iff (sys_rst)
        state_q == ST_WORD && rx_beat.valid && rx_beat.data == CH_SPACE && word_len_q != '0
        |=> state_q == ST_PARAM;
    endproperty
    a_space_opens_param: assert property (p_space_opens_param) else $error("space did not open param");

    property p_bad_char_skips;
        @(posedge clk) disable iff (sys_rst)
        state_q == ST_PARAM && rx_beat.valid && rx_beat.data != CH_CR && !is_param_char(rx_beat.data)
        |=> state_q == ST_SKIP;
    endproperty
    a_bad_char_skips: assert property (p_bad_char_skips) else $error("bad parameter accepted");

    property p_write_applies;
        @(posedge clk) disable iff (sys_rst)
        state_q == ST_EXEC && remote_active && is_sp_wr && param_len_q != '0
        |=> first_working_setpoint == $past(scaled);
    endproperty
    a_write_applies: assert property (p_write_applies) else $error("setpoint not written");

    // Counts how long the current reply has been on the line.
    always_ff @(posedge clk)
    begin
        if (sys_rst || !(state_q == ST_REPLY || state_q == ST_LF))
            reply_cnt_q <= '0;
        else if (reply_cnt_q != 32'(REPLY_LIMIT))
            reply_cnt_q <= reply_cnt_q + 32'h00000001;
    end

    property p_query_answered;
        @(posedge clk) disable iff (sys_rst)
        state_q == ST_EXEC && is_query |=> state_q == ST_REPLY;
    endproperty
    a_query_answered: assert property (p_query_answered) else $error("query not answered");

    property p_reply_bounded;
        @(posedge clk) disable iff (sys_rst)
        state_q == ST_REPLY || state_q == ST_LF |-> reply_cnt_q != 32'(REPLY_LIMIT);
    endproperty
    a_reply_bounded: assert property (p_reply_bounded) else $error("reply not finished in time");

    property p_lf_last;
        @(posedge clk) disable iff (sys_rst)
        state_q == ST_LF |-> tx_beat.valid && tx_beat.data == CH_LF;
    endproperty
    a_lf_last: assert property (p_lf_last) else $error("reply not closed by LF");

    property p_local_write_ignored;
        @(posedge clk) disable iff (sys_rst)
        state_q == ST_EXEC && !remote_active && !(remote_menu_on && !remote_active)
        |=> $stable(first_working_setpoint) && $stable(run_q);
    endproperty
    a_local_write_ignored: assert property (p_local_write_ignored) else $error("write outside remote");

    property p_enter_remote_stop;
        @(posedge clk) disable iff (sys_rst)
        remote_menu_on && !remote_active |=> !run_q ##1 remote_stop_shown;
    endproperty
    a_enter_remote_stop: assert property (p_enter_remote_stop) else $error("remote stop not shown");

    property p_reset_stopped;
        @(posedge clk) sys_rst |=> !run_q && !unit_run;
    endproperty
    a_reset_stopped: assert property (p_reset_stopped) else $error("runs after reset");

    c_write:  cover property (@(posedge clk) state_q == ST_EXEC && remote_active && is_sp_wr);
    c_query:  cover property (@(posedge clk) state_q == ST_LF && tx_take);
    c_remote: cover property (@(posedge clk) remote_menu_on && !remote_active);

endmodule

/* sim/host_link.sv */
// Host computer model: sends ASCII command frames and collects reply bytes.
// Assumes 8 data bits, no parity, one stop bit, DIV clocks per bit.
`timescale 1ns/100ps
module host_link
#(
    parameter int DIV = 10
)(
    input  wire logic clk,
    input  wire logic txd,
    output logic      rxd
);
    logic [7:0] rx_q[$];

    // The line idles at the mark level between characters.
    initial rxd = 1'b1;

    // Start bit, LSB first data, stop bit, all at the shared rate.
    task automatic send_byte(input logic [7:0] b);
        logic [9:0] f;
        f = {1'b1, b, 1'b0};
        for (int i = 0; i < 10; i++)
        begin
            rxd = f[i];
            repeat (DIV) @(negedge clk);
        end
    endtask

    // A nonzero gap models a slow host that pauses between characters.
    task automatic send_str(input string s, input int gap);
        for (int i = 0; i < s.len(); i++)
        begin
            send_byte(s[i]);
            repeat (gap) @(negedge clk);
        end
    endtask

    always
    begin
        logic [7:0] b;
        @(negedge clk);
        if (txd === 1'b0)
        begin
            repeat (DIV / 2) @(negedge clk);
            for (int i = 0; i < 8; i++)
            begin
                repeat (DIV) @(negedge clk);
                b[i] = txd;
            end
            repeat (DIV) @(negedge clk);
            rx_q.push_back(b);
        end
    end
endmodule

/* sim/serial_remote_command_handler_bench.sv */
// Self-checking bench of the remote command handler against a host model.
// Assumes the link runs at ten clocks per bit, 8N1.
`timescale 1ns/100ps
module serial_remote_command_handler_bench;
    import remote_cmd_pkg::*;
    localparam int DIV = 10;
    logic               clk;
    logic               sys_rst;
    logic               rxd;
    logic               remote_menu_on;
    logic               local_run;
    logic               txd;
    logic               remote_active;
    logic               remote_stop_shown;
    logic               unit_run;
    logic signed [23:0] first_working_setpoint;
    int                 num_errors = 0;
    int                 checks = 0;
    int                 cycles = 0;
    string              sp_wr;
    string              sp_rd;

    serial_remote_command_handler #(.BAUD(10_000_000)) dut (
        .clk                    (clk),
        .sys_rst                (sys_rst),
        .rxd                    (rxd),
        .remote_menu_on         (remote_menu_on),
        .local_run              (local_run),
        .txd                    (txd),
        .remote_active          (remote_active),
        .remote_stop_shown      (remote_stop_shown),
        .unit_run               (unit_run),
        .first_working_setpoint (first_working_setpoint)
    );

    host_link #(.DIV(DIV)) host (
        .clk (clk),
        .txd (txd),
        .rxd (rxd)
    );

    initial
    begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    task automatic results();
        if (num_errors == 0 && checks > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    // A whole run needs well under this many cycles.
    always @(posedge clk)
    begin
        cycles++;
        if (cycles == 40000)
        begin
            $display("[FAIL] %0t timeout", $time);
            num_errors++;
            results();
        end
    end

    task automatic cmp_bit(input logic got, input logic exp, input string m);
        checks++;
        if (got !== exp)
        begin
            $display("[FAIL] %0t %s", $time, m);
            num_errors++;
        end
    endtask

    task automatic cmp_word(input logic [23:0] got, input logic [23:0] exp, input string m);
        checks++;
        if (got !== exp)
        begin
            $display("[FAIL] %0t %s got %h", $time, m, got);
            num_errors++;
        end
    endtask

    // Turns a right-aligned command word into the text that goes on the line.
    function automatic string cmd_text(input logic [CMD_W-1:0] w);
        string s;
        s = "";
        for (int i = CMD_CHARS - 1; i >= 0; i--)
            if (w[8*i +: 8] != 8'h00)
                s = $sformatf("%s%c", s, w[8*i +: 8]);
        return s;
    endfunction

    // The fixed wait is the scaled command gap; a setting must draw no reply.
    task automatic setting(input string s, input int gap);
        host.rx_q.delete();
        host.send_str(s, gap);
        repeat (400) @(negedge clk);
        cmp_word(24'(host.rx_q.size()), 24'h000000, "reply to setting");
    endtask

    task automatic query(input string s, input string exp);
        host.rx_q.delete();
        host.send_str(s, 0);
        for (int n = 0; n < 3000 && host.rx_q.size() < exp.len(); n++)
            @(negedge clk);
        repeat (200) @(negedge clk);
        cmp_word(24'(host.rx_q.size()), 24'(exp.len()), "reply length");
        for (int i = 0; i < exp.len(); i++)
            cmp_word({16'h0000, host.rx_q[i]}, {16'h0000, exp[i]}, "reply byte");
    endtask

    task automatic t_reset();
        cmp_bit(txd, 1'b1, "txd idle");
        cmp_bit(remote_active, 1'b0, "remote after reset");
        cmp_bit(unit_run, 1'b0, "run after reset");
        cmp_word(first_working_setpoint, 24'h000000, "setpoint after reset");
    endtask

    task automatic t_local();
        local_run = 1'b1;
        setting({sp_wr, " 55.5\r"}, 0);
        cmp_word(first_working_setpoint, 24'h000000, "setting in local");
        setting("OUT_MODE_05 0\r", 0);
        cmp_bit(unit_run, 1'b1, "stop in local");
        query({sp_rd, "\r"}, "0\n");
    endtask

    task automatic t_enter();
        remote_menu_on = 1'b1;
        repeat (4) @(negedge clk);
        cmp_bit(remote_active, 1'b1, "remote entry");
        cmp_bit(unit_run, 1'b0, "run on entry");
        cmp_bit(remote_stop_shown, 1'b1, "stop shown");
    endtask

    task automatic t_setpoint();
        setting({sp_wr, " 55.5\r"}, 0);
        cmp_word(first_working_setpoint, 24'h0015AE, "setpoint 55.5");
        query({sp_rd, "\r"}, "55.5\n");
        setting({sp_wr, " -12.25\r"}, 37);
        cmp_word(first_working_setpoint, 24'hFFFB37, "setpoint -12.25");
        query({sp_rd, "\r"}, "-12.25\n");
        setting({sp_wr, " 7A\r"}, 0);
        cmp_word(first_working_setpoint, 24'hFFFB37, "bad parameter taken");
    endtask

    task automatic t_run();
        setting("OUT_MODE_05 1\r", 0);
        cmp_bit(unit_run, 1'b1, "remote start");
        cmp_bit(remote_stop_shown, 1'b0, "stop cleared");
        query("IN_MODE_05\r", "1\n");
        query("IN_XX_99\r", "?\n");
        setting("OUT_MODE_05 0\r", 0);
        cmp_bit(unit_run, 1'b0, "remote stop");
        cmp_bit(remote_stop_shown, 1'b1, "stop shown again");
    endtask

    // Power return: the run state must not come back until the host resends it.
    task automatic t_power();
        setting("OUT_MODE_05 1\r", 0);
        sys_rst = 1'b1;
        repeat (3) @(negedge clk);
        sys_rst = 1'b0;
        repeat (3) @(negedge clk);
        cmp_bit(unit_run, 1'b0, "no restart");
        cmp_word(first_working_setpoint, 24'h000000, "setpoint lost");
        setting("OUT_MODE_05 1\r", 0);
        setting({sp_wr, " 20\r"}, 0);
        cmp_bit(unit_run, 1'b1, "restart by host");
        cmp_word(first_working_setpoint, 24'h0007D0, "setpoint resent");
    endtask

    initial
    begin
        sp_wr = cmd_text(SETPOINT_ONE_WRITE_CMD);
        sp_rd = cmd_text(SETPOINT_ONE_READ_CMD);
        sys_rst = 1'b1;
        remote_menu_on = 1'b0;
        local_run = 1'b0;
        repeat (12) @(negedge clk);
        sys_rst = 1'b0;
        repeat (3) @(negedge clk);
        t_reset();
        t_local();
        t_enter();
        t_setpoint();
        t_run();
        t_power();
        results();
    end
endmodule
